// *** pkg/mgos_regs.vh ***
/*
 * register map, field positions, reset values and axi response codes of the gate output stage.
 * assumes an axi4-lite slave with 32-bit data, one aligned word per register.
 */
`ifndef MGOS_REGS_VH
`define MGOS_REGS_VH

// byte offsets on the register bus
`define MGOS_OFS_MASK_ENABLE    12'h000
`define MGOS_OFS_MASK_DATA      12'h004
`define MGOS_OFS_DEAD_TIME      12'h008
`define MGOS_OFS_POLARITY       12'h00C
`define MGOS_OFS_CONTROL        12'h010
`define MGOS_OFS_STATUS         12'h014

// reset values
`define MGOS_RST_BYTE           8'h00

// dead_time_setup fields
`define MGOS_DT_COUNT_MSB       4
`define MGOS_DT_ENABLE_BIT      5
`define MGOS_DT_CLKSEL_LSB      6
`define MGOS_DT_CLKSEL_MSB      7

// control register fields
`define MGOS_CTL_BRAKE_BIT      0
`define MGOS_CTL_PROTACT_BIT    1
`define MGOS_CTL_MASKMODE_BIT   2
`define MGOS_CTL_OUTEN_BIT      3

// axi responses
`define MGOS_RESP_OKAY          2'h0
`define MGOS_RESP_SLVERR        2'h2

`endif

// *** hw/mgos_gate_output_stage.v ***
/*
 * motor gate output stage: software mask, protection, brake, staggered guard,
 * rising-edge dead time and pin polarity for four gate-driver outputs, with an
 * axi4-lite register slave.
 * assumes generator, hardware-table and protect inputs synchronous to clk.
 */
`include "mgos_regs.vh"

module mgos_gate_output_stage #(
    parameter CH = 4                         // gate channels: ah, al, bh, bl
) (
    input  wire          clk,
    input  wire          rst_n,
    input  wire [11:0]   s_axi_awaddr,
    input  wire          s_axi_awvalid,
    output reg           s_axi_awready,
    input  wire [31:0]   s_axi_wdata,
    input  wire [3:0]    s_axi_wstrb,
    input  wire          s_axi_wvalid,
    output reg           s_axi_wready,
    output reg  [1:0]    s_axi_bresp,
    output reg           s_axi_bvalid,
    input  wire          s_axi_bready,
    input  wire [11:0]   s_axi_araddr,
    input  wire          s_axi_arvalid,
    output reg           s_axi_arready,
    output reg  [31:0]   s_axi_rdata,
    output reg  [1:0]    s_axi_rresp,
    output reg           s_axi_rvalid,
    input  wire          s_axi_rready,
    input  wire [CH-1:0] pwm_gen,            // generator signals, bit order ah, al, bh, bl
    input  wire [CH-1:0] hw_mask_drive,      // hardware-table result
    input  wire          protect,            // protection trigger, active high
    output reg           a_high_pin_o,
    output reg           a_high_pin_oe,
    output reg           a_low_pin_o,
    output reg           a_low_pin_oe,
    output reg           b_high_pin_o,
    output reg           b_high_pin_oe,
    output reg           b_low_pin_o,
    output reg           b_low_pin_oe
);

    // software-visible registers
    reg  [7:0]    pwm_mask_enable_q;        // low nibble used
    reg  [7:0]    pwm_mask_data_q;          // low nibble used
    reg  [7:0]    dead_time_setup_q;        // clksel, enable, count
    reg  [7:0]    gate_output_polarity_q;   // low nibble used
    reg  [3:0]    control_q;                // brake, action, mask mode, output enable

    // bus slave state
    reg           aw_hold_q;                // write address captured
    reg  [11:0]   aw_addr_q;
    reg           w_hold_q;                 // write data captured
    reg  [31:0]   w_data_q;
    reg  [3:0]    w_strb_q;

    // datapath state
    reg  [2:0]    div_cnt_q;                // prescaler for dead-time tick
    reg  [CH-1:0] level_q;                  // staggered-guard result seen by dead-time stage
    reg  [CH-1:0] dt_out_q;                 // dead-time stage output
    reg  [5:0]    dt_cnt_q [0:CH-1];        // per-channel remaining ticks
    integer       i;

    // register offsets; bits 11:2 pick the word, the low two are ignored
    localparam [11:0] OFS_MASK_ENABLE = `MGOS_OFS_MASK_ENABLE;
    localparam [11:0] OFS_MASK_DATA   = `MGOS_OFS_MASK_DATA;
    localparam [11:0] OFS_DEAD_TIME   = `MGOS_OFS_DEAD_TIME;
    localparam [11:0] OFS_POLARITY    = `MGOS_OFS_POLARITY;
    localparam [11:0] OFS_CONTROL     = `MGOS_OFS_CONTROL;
    localparam [11:0] OFS_STATUS      = `MGOS_OFS_STATUS;
    // control and dead-time fields named for the logic below

    wire          brake_control_bit  = control_q[`MGOS_CTL_BRAKE_BIT];
    wire          protect_action_bit = control_q[`MGOS_CTL_PROTACT_BIT];
    wire          mask_mode_select   = control_q[`MGOS_CTL_MASKMODE_BIT];
    wire          out_enable         = control_q[`MGOS_CTL_OUTEN_BIT];
    wire          dead_time_enable_bit = dead_time_setup_q[`MGOS_DT_ENABLE_BIT];
    wire [1:0]    dead_time_clock_select = dead_time_setup_q[`MGOS_DT_CLKSEL_MSB:`MGOS_DT_CLKSEL_LSB];
    wire [5:0]    dt_load = {1'b0, dead_time_setup_q[`MGOS_DT_COUNT_MSB:0]} + 6'h01;

    // output conditioning chain, combinational
    reg  [CH-1:0] masked;
    reg  [CH-1:0] overridden;
    reg  [CH-1:0] guarded;
    reg           dt_tick;
    always @* begin
        // software mask per channel, or the hardware table
        if (mask_mode_select) begin
            masked = (pwm_gen & ~pwm_mask_enable_q[3:0])
                   | (pwm_mask_data_q[3:0] & pwm_mask_enable_q[3:0]);
            // a pair masked both on is forced off
            // the staggered guard would catch this too; kept so the
            // mask stage alone already meets the pair rule for a fully masked pair
            if (pwm_mask_enable_q[1:0] == 2'b11 && pwm_mask_data_q[1:0] == 2'b11) begin
                masked[1:0] = 2'b00;
            end
            if (pwm_mask_enable_q[3:2] == 2'b11 && pwm_mask_data_q[3:2] == 2'b11) begin
                masked[3:2] = 2'b00;
            end
        end else begin
            // hardware table result taken as it stands
            masked = hw_mask_drive;
        end
    end

    // override stage; protect is a level and holds only while high
    always @* begin
        // brake tested first so it wins over protection and everything earlier
        if (brake_control_bit) begin
            overridden = 4'b1010;
        end else if (protect) begin
            overridden = protect_action_bit ? 4'b1010 : 4'b0000;
        end else begin
            overridden = masked;
        end
    end

    // staggered guard: a pair both on would short the supply
    always @* begin
        // bit0 ah, bit1 al, bit2 bh, bit3 bl: overridden above is {bl,bh,al,ah}={1,0,1,0}
        guarded = overridden;
        if (overridden[1:0] == 2'b11) begin
            guarded[1:0] = 2'b00;
        end
        if (overridden[3:2] == 2'b11) begin
            guarded[3:2] = 2'b00;
        end
    end

    // tick decode: /2, /4 and /8 fire on the last prescaler count
    always @* begin
        // one tick of the selected dead-time clock
        case (dead_time_clock_select)
            2'b00:   dt_tick = 1'b1;
            2'b01:   dt_tick = (div_cnt_q[0] == 1'b1);
            2'b10:   dt_tick = (div_cnt_q[1:0] == 2'b11);
            2'b11:   dt_tick = (div_cnt_q == 3'b111);
            default: dt_tick = 1'b1;
        endcase
    end

    // prescaler runs freely; phase against edges varies by up to one tick
    // a restart per edge would be exact, but one shared counter serves
    // all four channels, so the first tick of a count may come early
    always @(posedge clk) begin
        if (!rst_n) begin
            div_cnt_q <= 3'h0;
        end else begin
            div_cnt_q <= div_cnt_q + 3'h1;
        end
    end

    // dead-time insertion: rising edges wait, falling edges go at once
    // the counter loads count+1, so a zero setting still waits one tick
    always @(posedge clk) begin
        if (!rst_n) begin
            level_q  <= 4'h0;
            dt_out_q <= 4'h0;
            for (i = 0; i < CH; i = i + 1) begin
                dt_cnt_q[i] <= 6'h00;
            end
        end else begin
            // level_q is the guard output one cycle late; comparing both
            // finds the rising edge that starts a fresh count
            level_q <= guarded;
            for (i = 0; i < CH; i = i + 1) begin
                // dead time off: follow the guard with no wait
                if (!dead_time_enable_bit) begin
                    dt_out_q[i] <= guarded[i];
                    dt_cnt_q[i] <= 6'h00;
                end else if (!guarded[i]) begin
                    dt_out_q[i] <= 1'b0;
                    dt_cnt_q[i] <= 6'h00;
                end else if (!level_q[i]) begin
                    dt_cnt_q[i] <= dt_load;
                end else if (dt_cnt_q[i] != 6'h00) begin
                    if (dt_tick) begin
                        dt_cnt_q[i] <= dt_cnt_q[i] - 6'h01;
                        if (dt_cnt_q[i] == 6'h01) begin
                            dt_out_q[i] <= 1'b1;
                        end
                    end
                end else begin
                    dt_out_q[i] <= 1'b1;
                end
            end
        end
    end

    // pins: polarity last, released from high impedance only by output enable
    // every value and enable leaves a flip-flop, so the gate driver sees
    // no glitch when masks or overrides change together
    // the pins float out of reset until software sets output enable
    always @(posedge clk) begin
        if (!rst_n) begin
            a_high_pin_o  <= 1'b0;
            a_low_pin_o   <= 1'b0;
            b_high_pin_o  <= 1'b0;
            b_low_pin_o   <= 1'b0;
            a_high_pin_oe <= 1'b0;
            a_low_pin_oe  <= 1'b0;
            b_high_pin_oe <= 1'b0;
            b_low_pin_oe  <= 1'b0;
        end else begin
            a_high_pin_o  <= dt_out_q[0] ^ gate_output_polarity_q[0];
            a_low_pin_o   <= dt_out_q[1] ^ gate_output_polarity_q[1];
            b_high_pin_o  <= dt_out_q[2] ^ gate_output_polarity_q[2];
            b_low_pin_o   <= dt_out_q[3] ^ gate_output_polarity_q[3];
            a_high_pin_oe <= out_enable;
            a_low_pin_oe  <= out_enable;
            b_high_pin_oe <= out_enable;
            b_low_pin_oe  <= out_enable;
        end
    end

    // byte-lane merge for 8-bit registers: only lane 0 carries data
    // bits outside the mask are not stored and read back as zero
    function [7:0] mgos_merge;
        input [7:0] old;
        input [7:0] mask;
        begin
            mgos_merge = w_strb_q[0] ? (w_data_q[7:0] & mask) : old;
        end
    endfunction

    // a write completes only once both halves are held and the last answer
    // was taken, so bresp never changes under a waiting master
    wire do_write = aw_hold_q && w_hold_q && !s_axi_bvalid;

    // axi4-lite write path: address and data taken in either order
    always @(posedge clk) begin
        if (!rst_n) begin
            // bus state and all registers clear together
            aw_hold_q     <= 1'b0;
            aw_addr_q     <= 12'h000;
            w_hold_q      <= 1'b0;
            w_data_q      <= 32'h0000_0000;
            w_strb_q      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `MGOS_RESP_OKAY;
            pwm_mask_enable_q      <= `MGOS_RST_BYTE;
            pwm_mask_data_q        <= `MGOS_RST_BYTE;
            dead_time_setup_q      <= `MGOS_RST_BYTE;
            gate_output_polarity_q <= `MGOS_RST_BYTE;
            control_q              <= 4'h0;
        end else begin
            // address and data latch independently; either may come first
            // ready is high in the cycle before a capture can occur
            s_axi_awready <= !aw_hold_q && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= !w_hold_q && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_hold_q    <= 1'b0;
                w_hold_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `MGOS_RESP_OKAY;
                // unmapped offsets answer with an error and store nothing
                case (aw_addr_q[11:2])
                    OFS_MASK_ENABLE[11:2]: pwm_mask_enable_q <= mgos_merge(pwm_mask_enable_q, 8'h0F);
                    OFS_MASK_DATA[11:2]:   pwm_mask_data_q <= mgos_merge(pwm_mask_data_q, 8'h0F);
                    OFS_DEAD_TIME[11:2]:   dead_time_setup_q <= mgos_merge(dead_time_setup_q, 8'hFF);
                    OFS_POLARITY[11:2]:    gate_output_polarity_q <= mgos_merge(gate_output_polarity_q, 8'h0F);
                    OFS_CONTROL[11:2]: begin
                        if (w_strb_q[0]) begin
                            control_q <= w_data_q[3:0];
                        end
                    end
                    OFS_STATUS[11:2]:      s_axi_bresp <= `MGOS_RESP_OKAY;  // read-only, write ignored
                    default:                    s_axi_bresp <= `MGOS_RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // axi4-lite read path: one read at a time, data one cycle after address
    // status bits sample live state, so two reads may differ while a
    // dead-time count is running
    always @(posedge clk) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `MGOS_RESP_OKAY;
        end else begin
            // arready stays low while an answer waits, so reads never overlap
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `MGOS_RESP_OKAY;
                // unmapped offsets read zero with an error
                case (s_axi_araddr[11:2])
                    OFS_MASK_ENABLE[11:2]: s_axi_rdata <= {24'h00_0000, pwm_mask_enable_q};
                    OFS_MASK_DATA[11:2]:   s_axi_rdata <= {24'h00_0000, pwm_mask_data_q};
                    OFS_DEAD_TIME[11:2]:   s_axi_rdata <= {24'h00_0000, dead_time_setup_q};
                    OFS_POLARITY[11:2]:    s_axi_rdata <= {24'h00_0000, gate_output_polarity_q};
                    OFS_CONTROL[11:2]:     s_axi_rdata <= {28'h000_0000, control_q};
                    // live pre-polarity drives in bits 3:0, pin levels in 7:4
                    OFS_STATUS[11:2]:      s_axi_rdata <= {24'h00_0000, b_low_pin_o, b_high_pin_o,
                                                                a_low_pin_o, a_high_pin_o, dt_out_q};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `MGOS_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // mgos_gate_output_stage

// *** testbench/mgos_gate_chk.sv ***
/* port checker of the gate output stage: bus answers and pin release.
   assumes it is bound into every mgos_gate_output_stage instance. */
module mgos_gate_chk (
    input wire        clk,
    input wire        rst_n,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        a_high_pin_oe,
    input wire        a_low_pin_oe,
    input wire        b_high_pin_oe,
    input wire        b_low_pin_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // both halves of a write taken on one edge
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // pins must still float on the first edge out of reset
    a_reset_hiz: assert property ($rose(rst_n) |-> !(a_high_pin_oe || a_low_pin_oe || b_high_pin_oe || b_low_pin_oe))
        else $error("pins driven right after reset");
    // one enable bit releases all four pins together
    a_oe_same: assert property (a_high_pin_oe == a_low_pin_oe && b_high_pin_oe == b_low_pin_oe && a_high_pin_oe == b_high_pin_oe)
        else $error("pin enables disagree");
    // halves are held one edge, the register is written and answered the next
    a_write_resp: assert property (s_wr_take |=> ##1 s_axi_bvalid)
        else $error("no write answer two cycles after capture");
    a_ready_gap: assert property (s_wr_take |=> !s_axi_awready && !s_axi_wready)
        else $error("write readies not dropped after capture");
    a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
    a_read_resp: assert property (s_rd_take |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late or address ready kept");
    a_r_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    // registers are at most eight bits wide, the rest of the word reads zero
    a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");
endmodule // mgos_gate_chk

bind mgos_gate_output_stage mgos_gate_chk u_mgos_gate_chk (
    .clk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .a_high_pin_oe, .a_low_pin_oe, .b_high_pin_oe, .b_low_pin_oe
);

// *** testbench/mgos_gate_partner.sv ***
/* external gate transistor pairs: each pin level from value and enable.
   assumes pin order ah, al, bh, bl. */
module mgos_gate_partner (
    input  wire        clk,
    input  wire  [3:0] pin_o,
    input  wire  [3:0] pin_oe,
    output logic [3:0] pin_lvl
);
    logic flip_q = 1'b0; // toggles so a floating gate never reads steady
    always @(posedge clk) begin
        flip_q <= !flip_q;
    end
    // released pins wander rather than keep the last drive
    assign pin_lvl = (pin_o & pin_oe) | ({4{flip_q}} & ~pin_oe);
endmodule // mgos_gate_partner

// *** testbench/mgos_gate_output_stage_bench.sv ***
/* self-checking bench of the gate output stage, one task per scenario.
   assumes mgos_regs.vh on the include path and the checker bound by its file. */
`include "mgos_regs.vh"
module mgos_gate_output_stage_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;          // 40 mhz system clock
    logic        rst_n = 1'b0;        // held low for ten cycles
    logic [11:0] s_axi_awaddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b1; // answers always accepted
    logic [11:0] s_axi_araddr = '0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b1;
    logic [3:0]  pwm_gen = '0;        // ah, al, bh, bl
    logic [3:0]  hw_mask_drive = '0;
    logic        protect = 1'b0;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    wire         a_high_pin_o, a_high_pin_oe, a_low_pin_o, a_low_pin_oe;
    wire         b_high_pin_o, b_high_pin_oe, b_low_pin_o, b_low_pin_oe;
    wire  [3:0]  lvl;                 // resolved pin levels
    int          n_mismatch = 0;
    int          total_checks = 0;
    int          cyc = 0;
    always #12.5 clk = ~clk;
    mgos_gate_output_stage u_mgos_gate_output_stage (
        .clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pwm_gen, .hw_mask_drive, .protect,
        .a_high_pin_o, .a_high_pin_oe, .a_low_pin_o, .a_low_pin_oe,
        .b_high_pin_o, .b_high_pin_oe, .b_low_pin_o, .b_low_pin_oe
    );
    mgos_gate_partner u_mgos_gate_partner (
        .clk(clk), .pin_lvl(lvl),
        .pin_o({b_low_pin_o, b_high_pin_o, a_low_pin_o, a_high_pin_o}),
        .pin_oe({b_low_pin_oe, b_high_pin_oe, a_low_pin_oe, a_high_pin_oe})
    );
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // write: offer both halves, drop each once taken, then wait for the answer
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
        logic ah, wh, aw_ok, w_ok;
        logic [1:0] r;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(negedge clk);
            ah = s_axi_awvalid && s_axi_awready === 1'b1;
            wh = s_axi_wvalid && s_axi_wready === 1'b1;
            @(posedge clk);
            if (ah) s_axi_awvalid <= 1'b0;
            if (wh) s_axi_wvalid <= 1'b0;
            aw_ok |= ah;
            w_ok |= wh;
        end
        do begin
            @(negedge clk);
            ah = s_axi_bvalid === 1'b1;
            r = s_axi_bresp;
            @(posedge clk);
        end while (!ah);
        chk(r, er);
    endtask
    // read and compare data and response
    task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        logic ok;
        logic [31:0] d;
        logic [1:0] r;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(negedge clk);
            ok = s_axi_arready === 1'b1;
            @(posedge clk);
        end while (!ok);
        s_axi_arvalid <= 1'b0;
        do begin
            @(negedge clk);
            ok = s_axi_rvalid === 1'b1;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk);
        end while (!ok);
        chk(d, e);
        chk(r, er);
    endtask
    // two edges reach the pins with dead time off; two spare
    task automatic pins(input logic [3:0] e);
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk(lvl, e);
        @(posedge clk);
    endtask
    // cycles until the a-high pin shows v, bounded
    task automatic meas(input logic v, output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (lvl[0] !== v && n < 300);
        @(posedge clk);
    endtask
    task automatic t_reset;
        chk({b_low_pin_oe, b_high_pin_oe, a_low_pin_oe, a_high_pin_oe}, 4'h0);
        for (int i = 0; i < 6; i++) rdc(12'(i * 4), 32'h0000_0000, `MGOS_RESP_OKAY);
        rdc(12'h020, 32'h0000_0000, `MGOS_RESP_SLVERR);
        wr(`MGOS_OFS_MASK_DATA, 8'h0A, `MGOS_RESP_OKAY);
        rdc(`MGOS_OFS_MASK_DATA, 32'h0000_000A, `MGOS_RESP_OKAY);
        wr(12'h030, 8'h55, `MGOS_RESP_SLVERR);
        wr(`MGOS_OFS_MASK_DATA, 8'h00, `MGOS_RESP_OKAY);
    endtask
    // every generator pattern, pairs both high cut off
    task automatic t_pass;
        logic [3:0] e;
        wr(`MGOS_OFS_CONTROL, 8'h0C, `MGOS_RESP_OKAY);
        for (int i = 0; i < 16; i++) begin
            pwm_gen <= 4'(i);
            e = 4'(i);
            if (e[1:0] == 2'b11) e[1:0] = 2'b00;
            if (e[3:2] == 2'b11) e[3:2] = 2'b00;
            pins(e);
        end
    endtask
    task automatic t_mask;
        pwm_gen <= 4'b1000;
        wr(`MGOS_OFS_MASK_ENABLE, 8'h05, `MGOS_RESP_OKAY);
        wr(`MGOS_OFS_MASK_DATA, 8'h01, `MGOS_RESP_OKAY);
        pins(4'b1001);
        wr(`MGOS_OFS_MASK_ENABLE, 8'h03, `MGOS_RESP_OKAY);
        wr(`MGOS_OFS_MASK_DATA, 8'h03, `MGOS_RESP_OKAY);
        pins(4'b1000);
        hw_mask_drive <= 4'b0100;
        wr(`MGOS_OFS_CONTROL, 8'h08, `MGOS_RESP_OKAY);
        pins(4'b0100);
        wr(`MGOS_OFS_CONTROL, 8'h0C, `MGOS_RESP_OKAY);
    endtask
    // protection both ways, then brake over protection and mask
    task automatic t_prot;
        wr(`MGOS_OFS_MASK_ENABLE, 8'h00, `MGOS_RESP_OKAY);
        pwm_gen <= 4'b0101;
        protect <= 1'b1;
        pins(4'b0000);
        wr(`MGOS_OFS_CONTROL, 8'h0E, `MGOS_RESP_OKAY);
        pins(4'b1010);
        wr(`MGOS_OFS_CONTROL, 8'h0D, `MGOS_RESP_OKAY);
        pins(4'b1010);
        protect <= 1'b0;
        wr(`MGOS_OFS_MASK_ENABLE, 8'h0F, `MGOS_RESP_OKAY);
        wr(`MGOS_OFS_MASK_DATA, 8'h05, `MGOS_RESP_OKAY);
        pins(4'b1010);
        wr(`MGOS_OFS_MASK_ENABLE, 8'h00, `MGOS_RESP_OKAY);
        wr(`MGOS_OFS_CONTROL, 8'h0C, `MGOS_RESP_OKAY);
    endtask
    task automatic t_pol;
        pwm_gen <= 4'b0000;
        for (int i = 0; i < 4; i++) begin
            wr(`MGOS_OFS_POLARITY, 8'(1 << i), `MGOS_RESP_OKAY);
            pins(4'(1 << i));
        end
        rdc(`MGOS_OFS_POLARITY, 32'h0000_0008, `MGOS_RESP_OKAY);
        wr(`MGOS_OFS_POLARITY, 8'h00, `MGOS_RESP_OKAY);
    endtask
    // count 15 keeps every divider between 0.4 and 3.2 us
    task automatic t_dt;
        int n, dv;
        for (int c = 0; c < 4; c++) begin
            dv = 1 << c;
            wr(`MGOS_OFS_DEAD_TIME, {2'(c), 1'b1, 5'd15}, `MGOS_RESP_OKAY);
            pwm_gen <= 4'b0001;
            meas(1'b1, n);
            // sixteen ticks, the first early by up to dv-1, plus three edges
            chk(n >= 15 * dv + 4 && n <= 16 * dv + 3, 1'b1);
            pwm_gen <= 4'b0000;
            meas(1'b0, n);
            chk(n <= 5, 1'b1);
        end
        wr(`MGOS_OFS_DEAD_TIME, 8'hCF, `MGOS_RESP_OKAY);
        pwm_gen <= 4'b0001;
        meas(1'b1, n);
        chk(n <= 5, 1'b1);
    endtask
    // reset in mid-run with the pins driven: they must float again
    task automatic t_rst2;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        chk({b_low_pin_oe, b_high_pin_oe, a_low_pin_oe, a_high_pin_oe}, 4'h0);
        @(posedge clk);
        rdc(`MGOS_OFS_CONTROL, 32'h0000_0000, `MGOS_RESP_OKAY);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // hang guard well above the several hundred cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            end_sim();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_pass();
        t_mask();
        t_prot();
        t_pol();
        t_dt();
        t_rst2();
        end_sim();
    end
endmodule // mgos_gate_output_stage_bench
